// >>> bench/ssh_fw_model.sv
// Firmware and media partner model for the SMART subcommand handler
module ssh_fw_model (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic fw_req_in,
  input wire logic [7:0] fw_log_addr_in,
  input wire logic [8:0] media_index_in,
  input wire logic [7:0] delay_in,
  output logic fw_done_out,
  output logic [7:0] media_rd_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Firmware answer
  // ------------------------------------------------------------
  logic [7:0] cnt = 8'h00; // Cycles waited on the pending request
  logic answered = 1'b0; // Blocks a second answer to one request
  initial fw_done_out = 1'b0;
  // One done pulse per request, after delay_in cycles; the request
  // must drop before the model will answer again
  always @(posedge clk_sys_in) begin
    fw_done_out <= 1'b0;
    if (!nrst_in || !fw_req_in) begin
      cnt <= 8'h00;
      answered <= 1'b0;
    end else if (!answered) begin
      if (cnt >= delay_in) begin
        fw_done_out <= 1'b1;
        answered <= 1'b1;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
  // ------------------------------------------------------------
  // Media contents
  // ------------------------------------------------------------
  // Byte depends on log address and index, so a wrong log or a
  // skipped index shows up in the read stream
  assign media_rd_data_out = media_index_in[7:0] ^ fw_log_addr_in ^
    {7'h00, media_index_in[8]};
endmodule

// >>> bench/test_smart_subcommand_handler.sv
// Self-checking bench for the SMART subcommand handler
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  err_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module test_smart_subcommand_handler;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0; // Held low for six cycles
  logic cmd_strobe_in = 1'b0;
  logic [7:0] features_register_in = 8'h00;
  logic [7:0] sector_number_register_in = 8'h00;
  logic [7:0] sector_count_register_in = 8'h00;
  logic host_wr_valid_in = 1'b0;
  logic [7:0] host_wr_data_in = 8'h00;
  logic host_rd_ready_in = 1'b0;
  logic [7:0] fw_delay = 8'h02; // Firmware answer delay
  logic busy_out, error_out, host_wr_ready_out, host_rd_valid_out;
  logic [7:0] host_rd_data_out, fw_log_addr_out, media_rd_data_in;
  logic fw_req_out, fw_done_in, media_wr_out;
  logic [3:0] fw_func_out;
  logic [8:0] media_index_out;
  logic [7:0] media_wr_data_out;
  logic [3:0] last_fn; // Function seen at the last firmware answer
  logic [7:0] last_addr; // Log address seen at that answer
  logic [31:0] seed = 32'h56ff83a6;
  int err_count = 0;
  int num_checks = 0;
  logic [7:0] rxq[$]; // Bytes accepted from the read stream
  logic [7:0] mwq[$]; // Bytes written to the media
  logic [7:0] wq[512]; // Bytes offered on the write stream
  // Exec-immediate selectors and the function each should start
  logic [7:0] sel[6] = '{8'h00, 8'h01, 8'h02, 8'h7f, 8'h81, 8'h82};
  logic [3:0] efn[6] = '{4'h2, 4'h3, 4'h5, 4'h7, 4'h4, 4'h6};
  // ------------------------------------------------------------
  // Clock, instances and observers
  // ------------------------------------------------------------
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  ssh_handler i_ssh_handler (.clk_sys_in, .nrst_in, .cmd_strobe_in,
    .features_register_in, .sector_number_register_in,
    .sector_count_register_in, .busy_out, .error_out,
    .host_wr_valid_in, .host_wr_data_in, .host_wr_ready_out,
    .host_rd_valid_out, .host_rd_data_out, .host_rd_ready_in,
    .fw_req_out, .fw_func_out, .fw_log_addr_out, .fw_done_in,
    .media_index_out, .media_rd_data_in, .media_wr_out,
    .media_wr_data_out);
  ssh_fw_model i_ssh_fw_model (.clk_sys_in, .nrst_in,
    .fw_req_in(fw_req_out), .fw_log_addr_in(fw_log_addr_out),
    .media_index_in(media_index_out), .delay_in(fw_delay),
    .fw_done_out(fw_done_in), .media_rd_data_out(media_rd_data_in));
  // Both sides sample pre-edge values, so no race with the design
  always @(posedge clk_sys_in) begin
    if (host_rd_valid_out && host_rd_ready_in) rxq.push_back(host_rd_data_out);
    if (media_wr_out) mwq.push_back(media_wr_data_out);
    if (fw_done_in) begin
      last_fn <= fw_func_out;
      last_addr <= fw_log_addr_out;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One command strobe, then busy and error one settled cycle later
  task automatic issue(input logic [7:0] fr, sn, sc, input logic bad);
    @(negedge clk_sys_in);
    features_register_in = fr;
    sector_number_register_in = sn;
    sector_count_register_in = sc;
    cmd_strobe_in = 1'b1;
    @(negedge clk_sys_in);
    cmd_strobe_in = 1'b0;
    @(negedge clk_sys_in);
    `CHK("error", bad, error_out)
    `CHK("busy", ~bad, busy_out)
  endtask
  // Bounded wait for busy to drop; a hang ends the run
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 5000) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 5000) begin
      err_count++;
      give_verdict;
    end
  endtask
  task automatic do_fn(input logic [7:0] fr, sn, input logic [3:0] fn);
    seed = lfsr(seed);
    fw_delay = {4'h0, seed[3:0]}; // Prompt and slow firmware
    issue(fr, sn, 8'h00, 1'b0);
    wait_idle;
    `CHK("function", fn, last_fn)
  endtask
  // Read one sector; ready starts low so the buffer fills and stalls
  task automatic read_log(input logic [7:0] a, sc);
    int n;
    rxq.delete();
    issue(8'hd5, a, sc, 1'b0);
    for (n = 0; rxq.size() < 512 && n < 5000; n++) begin
      @(negedge clk_sys_in);
      seed = lfsr(seed);
      host_rd_ready_in = (n > 20) && (seed[0] | seed[1]);
    end
    if (n >= 5000) begin
      err_count++;
      give_verdict;
    end
    host_rd_ready_in = 1'b1;
    wait_idle;
    repeat (4) @(negedge clk_sys_in);
    `CHK("rd count", 512, rxq.size())
    for (int i = 0; i < 512; i++) begin
      `CHK("rd byte", 8'(i) ^ a ^ 8'(i >> 8), rxq[i])
    end
    `CHK("rd func", 4'h8, last_fn)
    `CHK("rd addr", a, last_addr)
    host_rd_ready_in = 1'b0;
  endtask
  // Write one sector with gaps in valid, plus a strobe while busy
  task automatic write_log(input logic [7:0] a);
    int i;
    int n;
    logic will;
    for (i = 0; i < 512; i++) begin
      seed = lfsr(seed);
      wq[i] = seed[7:0];
    end
    mwq.delete();
    issue(8'hd6, a, 8'h00, 1'b0);
    features_register_in = 8'hd3;
    cmd_strobe_in = 1'b1; // Taken only when idle, so ignored
    i = 0;
    will = 1'b0;
    for (n = 0; i < 512 && n < 5000; n++) begin
      @(negedge clk_sys_in);
      cmd_strobe_in = 1'b0;
      if (will) i++;
      if (will || !host_wr_valid_in) begin
        seed = lfsr(seed);
        host_wr_valid_in = (i < 512) && seed[0];
        host_wr_data_in = wq[i % 512];
      end
      will = host_wr_valid_in && host_wr_ready_out;
    end
    if (n >= 5000) begin
      err_count++;
      give_verdict;
    end
    host_wr_valid_in = 1'b0;
    wait_idle;
    repeat (3) @(negedge clk_sys_in);
    `CHK("idle", 1'b0, busy_out)
    `CHK("wr count", 512, mwq.size())
    for (i = 0; i < 512; i++) begin
      `CHK("wr byte", wq[i], mwq[i])
    end
    `CHK("wr func", 4'h9, last_fn)
    `CHK("wr addr", a, last_addr)
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    do_fn(8'hd3, 8'h00, 4'h1);
    for (int k = 0; k < 6; k++) begin
      do_fn(8'hd4, sel[k], efn[k]);
    end
    issue(8'hd4, 8'h03, 8'h00, 1'b1);
    issue(8'hda, 8'h00, 8'h00, 1'b1);
    read_log(8'h01, 8'h01);
    read_log(8'h06, 8'h01);
    read_log(8'h8f, 8'h00);
    issue(8'hd5, 8'h01, 8'h02, 1'b1);
    issue(8'hd5, 8'h06, 8'h00, 1'b1);
    issue(8'hd5, 8'h07, 8'h01, 1'b1);
    write_log(8'h80);
    write_log(8'h9f);
    issue(8'hd6, 8'h7f, 8'h01, 1'b1);
    issue(8'hd6, 8'ha0, 8'h01, 1'b1);
    give_verdict;
  end
endmodule

// >>> rtl/ssh_handler.sv
// SMART subcommand decoder, busy control and 512-byte log transfer
// --------------------------------------------------------------
// How it works
// - Save subcommand sets busy, then stores attributes
// - Busy clears once attributes are stored
// - Execute-immediate runs selected test or aborts
// - Selector 00h off-line collect, 7Fh aborts test
// - 01h quick off-line, 81h quick captive
// - 02h comprehensive off-line, 82h comprehensive captive
// - Read-log returns exactly one 512-byte block
// - Address 01h, count 01h selects error log
// - Address 06h, count 01h selects self-test log
// - Features register code picks the subcommand
// --------------------------------------------------------------
module ssh_handler (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Task-file side
  input wire logic cmd_strobe_in, // One-cycle: SMART command written
  input wire logic [7:0] features_register_in,
  input wire logic [7:0] sector_number_register_in,
  input wire logic [7:0] sector_count_register_in,
  output logic busy_out, // BSY flag
  output logic error_out, // Abort: bad subcommand or address
  // Host byte stream into the drive (write-log)
  input wire logic host_wr_valid_in,
  input wire logic [7:0] host_wr_data_in,
  output logic host_wr_ready_out,
  // Drive byte stream to the host (read-log)
  output logic host_rd_valid_out,
  output logic [7:0] host_rd_data_out,
  input wire logic host_rd_ready_in,
  // Firmware / media side
  output logic fw_req_out, // Level: function pending
  output logic [3:0] fw_func_out, // ssh_fn_e code
  output logic [7:0] fw_log_addr_out, // Log address of the request
  input wire logic fw_done_in, // One-cycle: function finished
  output logic [8:0] media_index_out, // Byte index within sector
  input wire logic [7:0] media_rd_data_in, // Log byte at index
  output logic media_wr_out, // One-cycle byte write strobe
  output logic [7:0] media_wr_data_out
);
  // --------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------
  // Map a selector code to a firmware function
  function automatic ssh_pkg::ssh_fn_e sel_fn(input logic [7:0] sel);
    case (sel)
      ssh_pkg::SEL_OFFLINE: sel_fn = ssh_pkg::SSH_FN_OFFLINE;
      ssh_pkg::SEL_ABORT: sel_fn = ssh_pkg::SSH_FN_ABORT;
      ssh_pkg::SEL_QUICK_OFF: sel_fn = ssh_pkg::SSH_FN_QUICK_OFF;
      ssh_pkg::SEL_QUICK_CAP: sel_fn = ssh_pkg::SSH_FN_QUICK_CAP;
      ssh_pkg::SEL_COMP_OFF: sel_fn = ssh_pkg::SSH_FN_COMP_OFF;
      ssh_pkg::SEL_COMP_CAP: sel_fn = ssh_pkg::SSH_FN_COMP_CAP;
      default: sel_fn = ssh_pkg::SSH_FN_NONE;
    endcase
  endfunction

  // Host-defined log range, allowed for both reads and writes
  function automatic logic host_log(input logic [7:0] a);
    host_log = (a >= ssh_pkg::LOG_HOST_LO) && (a <= ssh_pkg::LOG_HOST_HI);
  endfunction

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef enum {
    SSH_IDLE, SSH_FW, SSH_RD_FETCH, SSH_RD_SEND, SSH_WR_RECV, SSH_WR_COMMIT
  } ssh_state_e;
  ssh_state_e state; // Sequencer state
  ssh_pkg::ssh_fn_e func; // Function in progress
  logic [7:0] log_addr; // Latched log address
  logic [9:0] byte_cnt; // Bytes moved in this sector
  logic log_ok_rd; // Read-log address valid
  logic log_ok_wr; // Write-log address valid
  ssh_pkg::ssh_fn_e dec_fn; // Decoded function this cycle
  localparam logic [9:0] LAST_BYTE = 10'(ssh_pkg::SECTOR_BYTES - 1);

  ssh_stream_if rd_up (); // Handler to buffer
  ssh_stream_if rd_dn (); // Buffer to host

  // Log-address checks: fixed logs need one sector in the count
  assign log_ok_rd = (sector_count_register_in == ssh_pkg::LOG_COUNT_ONE
      && (sector_number_register_in == ssh_pkg::LOG_ERROR
      || sector_number_register_in == ssh_pkg::LOG_SELFTEST))
      || host_log(sector_number_register_in);
  assign log_ok_wr = host_log(sector_number_register_in);

  // Subcommand decode from the features register
  always_comb begin
    case (features_register_in)
      ssh_pkg::FEAT_SAVE_ATTR: dec_fn = ssh_pkg::SSH_FN_SAVE;
      ssh_pkg::FEAT_EXEC_IMM: dec_fn = sel_fn(sector_number_register_in);
      ssh_pkg::FEAT_READ_LOG:
        dec_fn = log_ok_rd ? ssh_pkg::SSH_FN_RD_LOG : ssh_pkg::SSH_FN_NONE;
      ssh_pkg::FEAT_WRITE_LOG:
        dec_fn = log_ok_wr ? ssh_pkg::SSH_FN_WR_LOG : ssh_pkg::SSH_FN_NONE;
      default: dec_fn = ssh_pkg::SSH_FN_NONE;
    endcase
  end

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  // A strobe while busy is ignored; the host must wait for BSY low
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state <= SSH_IDLE;
      func <= ssh_pkg::SSH_FN_NONE;
      log_addr <= 8'h00;
      error_out <= 1'b0;
    end else begin
      case (state)
        SSH_IDLE: begin
          if (cmd_strobe_in) begin
            func <= dec_fn;
            log_addr <= sector_number_register_in;
            error_out <= (dec_fn == ssh_pkg::SSH_FN_NONE);
            case (dec_fn)
              ssh_pkg::SSH_FN_NONE: state <= SSH_IDLE;
              ssh_pkg::SSH_FN_RD_LOG: state <= SSH_RD_FETCH;
              ssh_pkg::SSH_FN_WR_LOG: state <= SSH_WR_RECV;
              default: state <= SSH_FW;
            endcase
          end
        end
        // Firmware stores attributes / starts or aborts the test
        SSH_FW: begin
          if (fw_done_in) begin
            state <= SSH_IDLE;
          end
        end
        // Firmware brings the log sector into reach
        SSH_RD_FETCH: begin
          if (fw_done_in) begin
            state <= SSH_RD_SEND;
          end
        end
        // Stream 512 bytes out through the buffer
        SSH_RD_SEND: begin
          if (byte_cnt == 10'(ssh_pkg::SECTOR_BYTES) && !rd_dn.valid) begin
            state <= SSH_IDLE;
          end
        end
        // Accept 512 bytes from the host
        SSH_WR_RECV: begin
          if (host_wr_valid_in && byte_cnt == LAST_BYTE) begin
            state <= SSH_WR_COMMIT;
          end
        end
        // Firmware saves the sector to the media
        SSH_WR_COMMIT: begin
          if (fw_done_in) begin
            state <= SSH_IDLE;
          end
        end
        default: state <= SSH_IDLE;
      endcase
    end
  end

  // Byte counter for both transfer directions
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      byte_cnt <= 10'h000;
    end else if (state == SSH_IDLE) begin
      byte_cnt <= 10'h000;
    end else if ((state == SSH_RD_SEND && rd_up.valid && rd_up.ready)
        || (state == SSH_WR_RECV && host_wr_valid_in)) begin
      byte_cnt <= byte_cnt + 10'h001;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // Busy is set the cycle after a strobe with a valid subcommand and held until the end
  assign busy_out = (state != SSH_IDLE);
  assign fw_req_out = (state == SSH_FW) || (state == SSH_RD_FETCH)
      || (state == SSH_WR_COMMIT);
  assign fw_func_out = func;
  assign fw_log_addr_out = log_addr;
  assign media_index_out = byte_cnt[8:0];
  assign host_wr_ready_out = (state == SSH_WR_RECV);

  // Write bytes go straight to the media buffer, registered
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      media_wr_out <= 1'b0;
      media_wr_data_out <= 8'h00;
    end else begin
      media_wr_out <= (state == SSH_WR_RECV) && host_wr_valid_in;
      if (host_wr_valid_in) begin
        media_wr_data_out <= host_wr_data_in;
      end
    end
  end

  // Read bytes pass the two-entry buffer so a host stall loses none
  assign rd_up.valid = (state == SSH_RD_SEND)
      && (byte_cnt < 10'(ssh_pkg::SECTOR_BYTES));
  assign rd_up.data = media_rd_data_in;
  assign rd_dn.ready = host_rd_ready_in;
  assign host_rd_valid_out = rd_dn.valid;
  assign host_rd_data_out = rd_dn.data;

  ssh_skid_buf #(.WIDTH(8)) u_buf (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .up(rd_up),
    .dn(rd_dn)
  );

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence strobe_save;
    cmd_strobe_in && !busy_out
        && features_register_in == ssh_pkg::FEAT_SAVE_ATTR;
  endsequence

  save_busy_a: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      strobe_save |=> busy_out && fw_func_out == 4'(ssh_pkg::SSH_FN_SAVE))
    else $error("save did not raise busy");

  save_done_a: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      state == SSH_FW && fw_done_in |=> !busy_out)
    else $error("busy not cleared after save");

  abort_sel_a: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      cmd_strobe_in && !busy_out
      && features_register_in == ssh_pkg::FEAT_EXEC_IMM
      && sector_number_register_in == ssh_pkg::SEL_ABORT
      |=> fw_req_out && fw_func_out == 4'(ssh_pkg::SSH_FN_ABORT))
    else $error("abort selector not honoured");

  quick_cap_a: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      cmd_strobe_in && !busy_out
      && features_register_in == ssh_pkg::FEAT_EXEC_IMM
      && sector_number_register_in == ssh_pkg::SEL_QUICK_CAP
      |=> fw_func_out == 4'(ssh_pkg::SSH_FN_QUICK_CAP))
    else $error("quick captive not selected");

  comp_off_a: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      cmd_strobe_in && !busy_out
      && features_register_in == ssh_pkg::FEAT_EXEC_IMM
      && sector_number_register_in == ssh_pkg::SEL_COMP_OFF
      |=> fw_func_out == 4'(ssh_pkg::SSH_FN_COMP_OFF))
    else $error("comprehensive off-line not selected");

  rd_count_a: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      byte_cnt <= 10'(ssh_pkg::SECTOR_BYTES))
    else $error("read-log sent more than one sector");

  bad_log_a: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      cmd_strobe_in && !busy_out
      && features_register_in == ssh_pkg::FEAT_WRITE_LOG
      && !host_log(sector_number_register_in)
      |=> !busy_out && error_out)
    else $error("write-log outside host range accepted");

  // Busy must hold through the last byte and into the media commit
  wr_busy_a: assert property (
      @(posedge clk_sys_in) disable iff (!nrst_in)
      state == SSH_WR_RECV |=> busy_out [*2])
    else $error("busy dropped during write transfer");
endmodule

// >>> rtl/ssh_pkg.sv
// Shared constants and types for the SMART subcommand handler
package ssh_pkg;
  // --------------------------------------------------------------
  // Subcommand codes carried in the features register
  // --------------------------------------------------------------
  localparam logic [7:0] FEAT_READ_ATTR = 8'hd0; // Read attribute values
  localparam logic [7:0] FEAT_SAVE_ATTR = 8'hd3; // Save attribute values
  localparam logic [7:0] FEAT_EXEC_IMM = 8'hd4;  // Off-line / self test
  localparam logic [7:0] FEAT_READ_LOG = 8'hd5;  // Read logging sector
  localparam logic [7:0] FEAT_WRITE_LOG = 8'hd6; // Write logging sector
  localparam logic [7:0] FEAT_RET_STAT = 8'hda;  // Return status
  // --------------------------------------------------------------
  // Execute-immediate selector codes (sector number register)
  // --------------------------------------------------------------
  localparam logic [7:0] SEL_OFFLINE = 8'h00;
  localparam logic [7:0] SEL_QUICK_OFF = 8'h01;
  localparam logic [7:0] SEL_COMP_OFF = 8'h02;
  localparam logic [7:0] SEL_ABORT = 8'h7f;
  localparam logic [7:0] SEL_QUICK_CAP = 8'h81;
  localparam logic [7:0] SEL_COMP_CAP = 8'h82;
  // --------------------------------------------------------------
  // Log addresses and sector count
  // --------------------------------------------------------------
  localparam logic [7:0] LOG_ERROR = 8'h01;
  localparam logic [7:0] LOG_SELFTEST = 8'h06;
  localparam logic [7:0] LOG_HOST_LO = 8'h80;
  localparam logic [7:0] LOG_HOST_HI = 8'h9f;
  localparam logic [7:0] LOG_COUNT_ONE = 8'h01;
  // Bytes in one logging sector
  localparam int unsigned SECTOR_BYTES = 512;
  // Function handed to the firmware
  typedef enum logic [3:0] {
    SSH_FN_NONE, SSH_FN_SAVE, SSH_FN_OFFLINE, SSH_FN_QUICK_OFF,
    SSH_FN_QUICK_CAP, SSH_FN_COMP_OFF, SSH_FN_COMP_CAP, SSH_FN_ABORT,
    SSH_FN_RD_LOG, SSH_FN_WR_LOG
  } ssh_fn_e;
endpackage

// >>> rtl/ssh_skid_buf.sv
// Two-entry byte buffer with valid/ready on both sides
module ssh_skid_buf #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  ssh_stream_if.snk up,
  ssh_stream_if.src dn
);
  // --------------------------------------------------------------
  // Storage: two slots addressed by read/write index
  // --------------------------------------------------------------
  logic [WIDTH-1:0] mem [2]; // Entry storage
  logic wr_idx; // Next slot to fill
  logic rd_idx; // Next slot to drain
  logic [1:0] count; // Entries held
  logic push;
  logic pop;

  // Handshakes: full and empty are exact
  assign up.ready = (count != 2'h2);
  assign dn.valid = (count != 2'h0);
  assign dn.data = mem[rd_idx];
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  // Slot write
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_idx] <= up.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_idx <= ~wr_idx;
      end
      if (pop) begin
        rd_idx <= ~rd_idx;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// >>> rtl/ssh_stream_if.sv
// Valid/ready byte stream carrier between the handler and its buffer
interface ssh_stream_if;
  logic valid; // Byte offered
  logic ready; // Byte accepted
  logic [7:0] data; // Byte value
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
